/* core/scis_pkg.sv */
// Purpose: shared constants of the supply, reset and clock integrity block
// Assumes: 8-bit register port, 10 MHz core clock
// Notes:   offsets are register indices on the plain register port
package scis_pkg;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;

    // register offsets
    localparam logic [3:0] OFS_INTEGRITY = 4'h0;
    localparam logic [3:0] OFS_EVT_STAT  = 4'h1;
    localparam logic [3:0] OFS_EVT_MASK  = 4'h2;
    localparam logic [3:0] OFS_OPTIONS   = 4'h3;

    // integrity register field positions
    localparam int unsigned BIT_IRQ_EN   = 6;
    localparam int unsigned BIT_DET_FLAG = 5;
    localparam int unsigned BIT_LVD_RF   = 4;
    localparam int unsigned BIT_WDG_RF   = 0;

    // event status / mask field positions
    localparam int unsigned EVT_DET_TOGGLE = 0;
    localparam int unsigned EVT_CFG_FAULT  = 1;
    localparam int unsigned EVT_W          = 2;

    // options register field positions
    localparam int unsigned OPT_DOUBLER = 0;
    localparam int unsigned OPT_LVD     = 1;
    localparam int unsigned OPT_RC      = 2;

    // values after reset
    localparam logic [7:0] RST_INTEGRITY = 8'h00;
    localparam logic [1:0] RST_EVT_STAT  = 2'h0;
    localparam logic [1:0] RST_EVT_MASK  = 2'h3;
    localparam logic [7:0] RST_RDATA     = 8'h00;

    // doubler input range and core clock rate, in kHz
    localparam int unsigned CLK_KHZ     = 10000;
    localparam int unsigned OSC_MIN_KHZ = 2000;
    localparam int unsigned OSC_MAX_KHZ = 4000;
endpackage

/* core/scis_osc_clock_gen.sv */
// Purpose: internal oscillator clock as an enable pulse on the core clock
// Assumes: oscillator pin well below half the core clock rate
// Notes:   one pulse per internal_osc_clock period
`timescale 1ns/10ps
module scis_osc_clock_gen
    import scis_pkg::*;
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic oscPin,
    input  wire logic doublerEn,
    output logic      oscTick
);
    logic oscMeta_q, oscSync_q, oscLast_q, halfPhase_q, oscTick_q;
    logic halfPhase_d, oscTick_d, riseSeen, anyEdge;

    always_comb begin
        riseSeen    = oscSync_q & ~oscLast_q;
        anyEdge     = oscSync_q ^ oscLast_q;
        halfPhase_d = halfPhase_q;
        oscTick_d   = 1'b0;
        if (doublerEn) begin
            // both input edges: twice the input frequency
            oscTick_d = anyEdge;
        end else if (riseSeen) begin
            // every second rising edge: input divided by two
            halfPhase_d = ~halfPhase_q;
            oscTick_d   = halfPhase_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            oscMeta_q   <= 1'b0;
            oscSync_q   <= 1'b0;
            oscLast_q   <= 1'b0;
            halfPhase_q <= 1'b0;
            oscTick_q   <= 1'b0;
        end else begin
            oscMeta_q   <= oscPin;
            oscSync_q   <= oscMeta_q;
            oscLast_q   <= oscSync_q;
            halfPhase_q <= halfPhase_d;
            oscTick_q   <= oscTick_d;
        end
    end

    assign oscTick = oscTick_q;
endmodule

/* core/supply_clock_integrity_status.sv */
// Purpose: system integrity status register, detector interrupt and
//          reset source flags, plus the internal oscillator clock source
// Assumes: register port on clk; watchdog and low-voltage reset requests
//          come from logic on clk; detector level comes from a pin
// Notes:   the reset source flags live on the power-on reset only
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module supply_clock_integrity_status
    import scis_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              porRstn,
    input  wire logic              wdgReset,
    input  wire logic              lvdReset,
    input  wire logic              optDoublerEn,
    input  wire logic              optLvdEn,
    input  wire logic              optRcSource,
    input  wire logic              oscPin,
    input  wire logic              detectorPin,
    input  wire logic              isrEnter,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic      [DATA_W-1:0] regRdata,
    output logic                   detectorIrq,
    output logic                   irq,
    output logic                   oscTick
);
    // pin, watchdog and low-voltage resets clear the ordinary control state; power-on reset alone does not
    logic sysRstn;
    assign sysRstn = rstn & ~wdgReset & ~lvdReset;

    // option latch: taken while in reset so software cannot change it
    logic optDoubler_q, optLvd_q, optRc_q;
    logic optDoubler_d, optLvd_d, optRc_d;

    always_comb begin
        optDoubler_d = optDoubler_q;
        optLvd_d     = optLvd_q;
        optRc_d      = optRc_q;
        if (!sysRstn) begin
            optDoubler_d = optDoublerEn;
            optLvd_d     = optLvdEn;
            optRc_d      = optRcSource;
        end
    end

    always_ff @(posedge clk) begin
        if (!porRstn) begin
            // power-on is a reset too, so the straps are taken here as well
            optDoubler_q <= optDoublerEn;
            optLvd_q     <= optLvdEn;
            optRc_q      <= optRcSource;
        end else begin
            optDoubler_q <= optDoubler_d;
            optLvd_q     <= optLvd_d;
            optRc_q      <= optRc_d;
        end
    end

    scis_osc_clock_gen u_osc (
        .clk       (clk),
        .rstn      (sysRstn),
        .oscPin    (oscPin),
        .doublerEn (optDoubler_q),
        .oscTick   (oscTick)
    );

    // detector level synchroniser; only the second stage feeds logic
    logic detMeta_q, detMeta_d, detSync_q, detSync_d, detFlag_q, detFlag_d;

    always_comb begin
        detMeta_d = detectorPin;
        detSync_d = detMeta_q;
        detFlag_d = detSync_q;
    end

    always_ff @(posedge clk) begin
        if (!sysRstn) begin
            detMeta_q <= 1'b0;
            detSync_q <= 1'b0;
            detFlag_q <= 1'b0;
        end else begin
            detMeta_q <= detMeta_d;
            detSync_q <= detSync_d;
            detFlag_q <= detFlag_d;
        end
    end

    logic detToggle;
    assign detToggle = detSync_q ^ detFlag_q;

    // register access decode
    logic wrInteg, wrMask, rdStat;
    assign wrInteg = regWr & (regAddr == OFS_INTEGRITY);
    assign wrMask  = regWr & (regAddr == OFS_EVT_MASK);
    assign rdStat  = regRd & (regAddr == OFS_EVT_STAT);

    // control bit and pending detector interrupt
    logic irqEn_q, irqEn_d, pend_q, pend_d;
    always_comb begin
        irqEn_d = irqEn_q;
        pend_d  = pend_q;
        if (wrInteg) begin
            irqEn_d = regWdata[BIT_IRQ_EN];
        end
        if (isrEnter) begin
            pend_d = 1'b0;
        end
        if (irqEn_q && detToggle) begin
            // a new toggle wins over a service entry in the same cycle
            pend_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!sysRstn) begin
            irqEn_q <= RST_INTEGRITY[BIT_IRQ_EN];
            pend_q  <= 1'b0;
        end else begin
            irqEn_q <= irqEn_d;
            pend_q  <= pend_d;
        end
    end

    assign detectorIrq = pend_q;

    // reset source flags survive pin and watchdog resets
    logic low_voltage_reset_flag_q, low_voltage_reset_flag_d, watchdog_reset_flag_q, watchdog_reset_flag_d;
    always_comb begin
        low_voltage_reset_flag_d = low_voltage_reset_flag_q;
        watchdog_reset_flag_d = watchdog_reset_flag_q;
        if (wrInteg && !regWdata[BIT_LVD_RF]) begin
            low_voltage_reset_flag_d = 1'b0;
        end
        if (wrInteg && !regWdata[BIT_WDG_RF]) begin
            watchdog_reset_flag_d = 1'b0;
        end
        if (wdgReset) begin
            watchdog_reset_flag_d = 1'b1;
        end
        if (lvdReset) begin
            // meaningless when the detector is disabled by option
            low_voltage_reset_flag_d = 1'b1;
            watchdog_reset_flag_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!porRstn) begin
            low_voltage_reset_flag_q <= RST_INTEGRITY[BIT_LVD_RF];
            watchdog_reset_flag_q <= RST_INTEGRITY[BIT_WDG_RF];
        end else begin
            low_voltage_reset_flag_q <= low_voltage_reset_flag_d;
            watchdog_reset_flag_q <= watchdog_reset_flag_d;
        end
    end

    // sticky event status, cleared by reading it
    logic [EVT_W-1:0] evtStat_q, evtStat_d, evtMask_q, evtMask_d, evtSet;
    logic             cfgFault;
    // doubler with the RC source must not happen; flag it if it does
    assign cfgFault = optDoubler_q & optRc_q;
    assign evtSet   = {cfgFault, pend_d & ~pend_q};

    always_comb begin
        evtStat_d = evtStat_q;
        evtMask_d = evtMask_q;
        if (rdStat) begin
            evtStat_d = '0;
        end
        evtStat_d = evtStat_d | evtSet;
        if (wrMask) begin
            evtMask_d = regWdata[EVT_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!sysRstn) begin
            evtStat_q <= RST_EVT_STAT;
            evtMask_q <= RST_EVT_MASK;
        end else begin
            evtStat_q <= evtStat_d;
            evtMask_q <= evtMask_d;
        end
    end

    assign irq = |(evtStat_q & evtMask_q);

    // read data, one cycle after the strobe; reserved bits read zero
    logic [DATA_W-1:0] rdata_q, rdata_d, integVal;
    always_comb begin
        integVal               = '0;
        integVal[BIT_IRQ_EN]   = irqEn_q;
        integVal[BIT_DET_FLAG] = detFlag_q;
        integVal[BIT_LVD_RF]   = low_voltage_reset_flag_q;
        integVal[BIT_WDG_RF]   = watchdog_reset_flag_q;
        rdata_d = RST_RDATA;
        if (regRd) begin
            case (regAddr)
                OFS_INTEGRITY: rdata_d = integVal;
                OFS_EVT_STAT:  rdata_d = {{(DATA_W-EVT_W){1'b0}}, evtStat_q};
                OFS_EVT_MASK:  rdata_d = {{(DATA_W-EVT_W){1'b0}}, evtMask_q};
                OFS_OPTIONS:   rdata_d = {5'h00, optRc_q, optLvd_q,
                                          optDoubler_q};
                default:       rdata_d = RST_RDATA;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!sysRstn) begin
            rdata_q <= RST_RDATA;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign regRdata = rdata_q;
endmodule

/* sim/scis_properties.sv */
// Purpose: port-level checks of the integrity status block
// Assumes: pins stay still around resets
// Notes:   pin delays count the two synchroniser flops and the flag
`timescale 1ns/10ps
module scis_properties
    import scis_pkg::*;
(
    input wire logic              clk,
    input wire logic              rstn,
    input wire logic              porRstn,
    input wire logic              wdgReset,
    input wire logic              lvdReset,
    input wire logic              oscPin,
    input wire logic              detectorPin,
    input wire logic              isrEnter,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic              regRd,
    input wire logic [DATA_W-1:0] regRdata,
    input wire logic              detectorIrq,
    input wire logic              irq,
    input wire logic              oscTick
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn || !porRstn || wdgReset || lvdReset);
    a_rdata_quiet: assert property (!regRd |=> regRdata == 8'h00)
        else $error("read data outside a read");
    a_rsvd_zero: assert property (regRd && regAddr == OFS_INTEGRITY
        |=> (regRdata & 8'h8E) == 8'h00) else $error("reserved bit set");
    a_flag_follows: assert property (regRd && regAddr == OFS_INTEGRITY
        |=> regRdata[BIT_DET_FLAG] == $past(detectorPin, 4))
        else $error("flag");
    a_irq_toggle: assert property ($rose(detectorIrq)
        |-> $past(detectorPin, 3) != $past(detectorPin, 4))
        else $error("pending without toggle");
    a_isr_clear: assert property (isrEnter
        && $past(detectorPin, 2) == $past(detectorPin, 3) |=> !detectorIrq)
        else $error("pending not cleared");
    a_unmapped_zero: assert property (regRd && regAddr > OFS_OPTIONS
        |=> regRdata == 8'h00) else $error("unmapped read");
    a_osc_edge: assert property (oscTick
        |-> $past(oscPin, 3) != $past(oscPin, 4)) else $error("tick");
    a_tick_single: assert property (oscTick |=> !oscTick)
        else $error("tick too long");
    a_reset_quiet: assert property (disable iff (!porRstn)
        wdgReset || lvdReset |=> !irq && !detectorIrq && !oscTick)
        else $error("output during reset");
    c_irq: cover property ($rose(detectorIrq));
    c_tick: cover property (oscTick);
    c_stat: cover property (regRd && regAddr == OFS_EVT_STAT);
endmodule
bind supply_clock_integrity_status scis_properties scis_properties_inst (
    .clk(clk), .rstn(rstn), .porRstn(porRstn), .wdgReset(wdgReset),
    .lvdReset(lvdReset), .oscPin(oscPin), .detectorPin(detectorPin),
    .isrEnter(isrEnter), .regAddr(regAddr), .regRd(regRd),
    .regRdata(regRdata), .detectorIrq(detectorIrq), .irq(irq),
    .oscTick(oscTick));

/* sim/tb_top.sv */
// Purpose: self-checking bench of the integrity status block
// Assumes: status read clears at the edge that takes the read
// Notes:   tick counts allow one off at the window edges
`timescale 1ns/10ps
module tb_top
    import scis_pkg::*;
;
    logic              clk, rstn, porRstn, wdgReset, lvdReset;
    logic              optDoublerEn, optLvdEn, optRcSource;
    logic              oscPin, detectorPin, isrEnter, regWr, regRd;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWdata, regRdata, d;
    logic              detectorIrq, irq, oscTick, det;
    int                n_errors, comparisons;
    always #50 clk = ~clk;
    supply_clock_integrity_status supply_clock_integrity_status_inst (
        .clk(clk), .rstn(rstn), .porRstn(porRstn), .wdgReset(wdgReset),
        .lvdReset(lvdReset), .optDoublerEn(optDoublerEn),
        .optLvdEn(optLvdEn), .optRcSource(optRcSource), .oscPin(oscPin),
        .detectorPin(detectorPin), .isrEnter(isrEnter),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .detectorIrq(detectorIrq),
        .irq(irq), .oscTick(oscTick));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check1(input logic got, input logic exp);
        check({7'h00, got}, {7'h00, exp});
    endtask
    function automatic logic [7:0] integ(input logic en);
        return {1'b0, en, det, 5'h00};
    endfunction
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 check(regRdata, e);
    endtask
    // p: pin reset, w: watchdog, l: low voltage; held two edges
    task automatic hit(input logic p, input logic w, input logic l);
        @(posedge clk);
        rstn <= !p;
        wdgReset <= w;
        lvdReset <= l;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        wdgReset <= 1'b0;
        lvdReset <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
    task automatic flip();
        @(posedge clk);
        det = ~det;
        detectorPin <= det;
        repeat (5 + $urandom_range(3)) @(posedge clk);
    endtask
    task automatic isr();
        @(posedge clk);
        isrEnter <= 1'b1;
        @(posedge clk);
        isrEnter <= 1'b0;
        #1 check1(detectorIrq, 1'b0);
    endtask
    // pin period of four cycles, 2.5 MHz, for 80 cycles
    task automatic osc_run(input logic dbl);
        int n;
        int e;
        n = 0;
        e = dbl ? 40 : 10;
        for (int i = 0; i < 80; i++) begin
            @(posedge clk);
            if (i % 2 == 0)
                oscPin <= ~oscPin;
            #1 n += int'(oscTick === 1'b1);
        end
        check1(n >= e - 1 && n <= e + 1, 1'b1);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        finish_test();
    end
    initial begin
        {clk, rstn, porRstn, wdgReset, lvdReset, optDoublerEn} = '0;
        {optRcSource, oscPin, detectorPin, isrEnter, regWr, regRd} = '0;
        {regAddr, regWdata, det, n_errors, comparisons} = '0;
        optLvdEn = 1'b1;
        void'($urandom(32'h8C75));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        porRstn <= 1'b1;
        rd(OFS_INTEGRITY, 8'h00);
        rd(OFS_OPTIONS, 8'h02);
        rd(OFS_EVT_MASK, 8'h03);
        rd(OFS_EVT_STAT, 8'h00);
        rd(4'hA, 8'h00);
        // software keeps the reserved bits clear
        d = 8'($urandom) & 8'h71;
        wr(OFS_INTEGRITY, d);
        rd(OFS_INTEGRITY, d & 8'h40);
        $display("test registers done");
        wr(OFS_INTEGRITY, 8'h40);
        repeat (3) begin
            flip();
            rd(OFS_INTEGRITY, integ(1'b1));
            check1(detectorIrq, 1'b1);
            check1(irq, 1'b1);
            isr();
            rd(OFS_EVT_STAT, 8'h01);
            check1(irq, 1'b0);
        end
        wr(OFS_EVT_MASK, 8'h00);
        flip();
        check1(detectorIrq, 1'b1);
        check1(irq, 1'b0);
        isr();
        rd(OFS_EVT_STAT, 8'h01);
        wr(OFS_EVT_MASK, 8'h03);
        $display("test detector done");
        hit(1'b0, 1'b1, 1'b0);
        rd(OFS_INTEGRITY, integ(1'b0) | 8'h01);
        hit(1'b1, 1'b0, 1'b0);
        rd(OFS_INTEGRITY, integ(1'b0) | 8'h01);
        wr(OFS_INTEGRITY, 8'h00);
        rd(OFS_INTEGRITY, integ(1'b0));
        hit(1'b0, 1'b1, 1'b1);
        rd(OFS_INTEGRITY, integ(1'b0) | 8'h10);
        wr(OFS_INTEGRITY, 8'h00);
        rd(OFS_INTEGRITY, integ(1'b0));
        $display("test reset flags done");
        osc_run(1'b0);
        optDoublerEn <= 1'b1;
        hit(1'b1, 1'b0, 1'b0);
        osc_run(1'b1);
        optRcSource <= 1'b1;
        hit(1'b1, 1'b0, 1'b0);
        rd(OFS_OPTIONS, 8'h07);
        rd(OFS_EVT_STAT, 8'h02);
        $display("test oscillator done");
        finish_test();
    end
endmodule
